// ### odm_diag_map.sv
`timescale 1ns/100ps
module odm_diag_map #(
    parameter logic [319:0] LIMITS          = '0,
    parameter logic [7:0]   BASE_CHECKSUM   = 8'h00,
    parameter logic [7:0]   EXT_CHECKSUM    = 8'h00,
    parameter logic [7:0]   DIAG_CHECKSUM   = 8'h00,
    parameter logic [7:0]   CAL_DEFAULT     = 8'h00,
    // arbitrary value, not a real assignment
    parameter logic [23:0]  MAKER_ID        = 24'h5A5A5A,
    parameter int           RESPONSE_CYCLES = odm_pkg::RESPONSE_CYCLES
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_b,
    // register port, bit 8 selects the diagnostic page
    input  wire logic [8:0]    regAddr,
    input  wire logic [7:0]    regWdata,
    input  wire logic          regWr,
    input  wire logic          regRd,
    output logic      [7:0]    regRdata,
    // module pins
    input  wire logic          txDisablePin,
    input  wire logic          txFaultPin,
    input  wire logic          rxLosPin,
    input  wire logic          dataReady,
    output logic               txOff,
    // live monitor samples
    input  wire logic [15:0]   liveTemp,
    input  wire logic [15:0]   liveSupply,
    input  wire logic [15:0]   liveBias,
    input  wire logic [15:0]   liveTxPower,
    input  wire logic [15:0]   liveRxPower,
    // per-unit identity, first character in the top byte
    input  wire logic [127:0]  serialNumber,
    input  wire logic [63:0]   dateCode
);

    odm_pkg::odm_state_s st_reg;
    odm_pkg::odm_state_s st_next;
    logic [7:0]          off;
    logic [7:0]          rb;
    logic [7:0]          statusByte;

    function automatic logic [15:0] limitOf(input logic [4:0] idx);
        limitOf = LIMITS[idx*16 +: 16];
    endfunction

    function automatic logic [7:0] byteOf(input logic [15:0] w, input logic lsb);
        byteOf = lsb ? w[7:0] : w[15:8];
    endfunction

    // temperature is two's complement, the rest plain counts
    function automatic logic above(input int q, input logic [15:0] v, input logic [15:0] lim);
        if (q == odm_pkg::Q_TEMP)
            above = $signed(v) > $signed(lim);
        else
            above = v > lim;
    endfunction

    function automatic logic below(input int q, input logic [15:0] v, input logic [15:0] lim);
        if (q == odm_pkg::Q_TEMP)
            below = $signed(v) < $signed(lim);
        else
            below = v < lim;
    endfunction

    assign off = regAddr[7:0];

    always_comb
    begin
        st_next = st_reg;
        rb = 8'h00;
        statusByte = 8'h00;

        // inputs are already synchronous; one register stage
        st_next.live[0] = liveTemp;
        st_next.live[1] = liveSupply;
        st_next.live[2] = liveBias;
        st_next.live[3] = liveTxPower;
        st_next.live[4] = liveRxPower;
        st_next.hwDisable = txDisablePin;
        st_next.txFault = txFaultPin;
        st_next.rxLos = rxLosPin;
        st_next.notReady = !dataReady;

        // limits are read-only, so the only writable bit is the soft disable
        if (regWr && regAddr[odm_pkg::PAGE_BIT] && off == odm_pkg::STATUS_CONTROL)
            st_next.softDisable = regWdata[odm_pkg::SC_SOFT_DISABLE_BIT];

        // acting within one cycle is far inside the response time
        st_next.txOff = txDisablePin | st_next.softDisable;

        // level flags: they follow the live value, nothing latches them
        for (int q = 0; q < odm_pkg::Q_RXPOWER; q++)
        begin
            st_next.alarmA[7-2*q] = above(q, st_reg.live[q], limitOf(5'(4*q)));
            st_next.alarmA[6-2*q] = below(q, st_reg.live[q], limitOf(5'(4*q+1)));
            st_next.warnA[7-2*q] = above(q, st_reg.live[q], limitOf(5'(4*q+2)));
            st_next.warnA[6-2*q] = below(q, st_reg.live[q], limitOf(5'(4*q+3)));
        end
        st_next.alarmB = 8'h00;
        st_next.warnB = 8'h00;
        st_next.alarmB[odm_pkg::FLAG_RX_HIGH_BIT] =
            above(odm_pkg::Q_RXPOWER, st_reg.live[4], limitOf(5'd16));
        st_next.alarmB[odm_pkg::FLAG_RX_LOW_BIT] =
            below(odm_pkg::Q_RXPOWER, st_reg.live[4], limitOf(5'd17));
        st_next.warnB[odm_pkg::FLAG_RX_HIGH_BIT] =
            above(odm_pkg::Q_RXPOWER, st_reg.live[4], limitOf(5'd18));
        st_next.warnB[odm_pkg::FLAG_RX_LOW_BIT] =
            below(odm_pkg::Q_RXPOWER, st_reg.live[4], limitOf(5'd19));

        statusByte[odm_pkg::SC_HW_DISABLE_BIT] = st_reg.hwDisable;
        statusByte[odm_pkg::SC_SOFT_DISABLE_BIT] = st_reg.softDisable;
        statusByte[odm_pkg::SC_TX_FAULT_BIT] = st_reg.txFault;
        statusByte[odm_pkg::SC_RX_LOS_BIT] = st_reg.rxLos;
        statusByte[odm_pkg::SC_NOT_READY_BIT] = st_reg.notReady;

        if (regAddr[odm_pkg::PAGE_BIT])
        begin
            if (off <= odm_pkg::LIMIT_LAST_BYTE)
                rb = byteOf(limitOf(off[5:1]), off[0]);
            else if (off >= odm_pkg::CAL_FIRST && off <= odm_pkg::CAL_LAST)
                rb = CAL_DEFAULT;
            else if (off == odm_pkg::DIAG_CHECKSUM)
                rb = DIAG_CHECKSUM;
            else if (off >= odm_pkg::LIVE_TEMPERATURE && off <= odm_pkg::LIVE_LAST_BYTE)
                rb = byteOf(st_reg.live[3'((off - odm_pkg::LIVE_TEMPERATURE) >> 1)],
                            off[0]);
            else
            begin
                case (off)
                    odm_pkg::STATUS_CONTROL:  rb = statusByte;
                    odm_pkg::ALARM_FLAGS_A:   rb = st_reg.alarmA;
                    odm_pkg::ALARM_FLAGS_B:   rb = st_reg.alarmB;
                    odm_pkg::WARNING_FLAGS_A: rb = st_reg.warnA;
                    odm_pkg::WARNING_FLAGS_B: rb = st_reg.warnB;
                    default:                  rb = 8'h00;
                endcase
            end
        end
        else
        begin
            if (off >= odm_pkg::ID_MAKER_FIRST && off <= odm_pkg::ID_MAKER_LAST)
                rb = MAKER_ID[(odm_pkg::ID_MAKER_LAST - off)*8 +: 8];
            else if (off >= odm_pkg::ID_SERIAL_FIRST && off <= odm_pkg::ID_SERIAL_LAST)
                rb = serialNumber[(odm_pkg::ID_SERIAL_LAST - off)*8 +: 8];
            else if (off >= odm_pkg::ID_DATE_FIRST && off <= odm_pkg::ID_DATE_LAST)
                rb = dateCode[(odm_pkg::ID_DATE_LAST - off)*8 +: 8];
            else
            begin
                case (off)
                    odm_pkg::ID_WAVE_MSB:      rb = odm_pkg::WAVELENGTH_NM[15:8];
                    odm_pkg::ID_WAVE_LSB:      rb = odm_pkg::WAVELENGTH_NM[7:0];
                    // stored values, never recomputed from the other bytes
                    odm_pkg::ID_BASE_CHECKSUM: rb = BASE_CHECKSUM;
                    odm_pkg::ID_EXT_CHECKSUM:  rb = EXT_CHECKSUM;
                    default:                   rb = 8'h00;
                endcase
            end
        end

        // read data only in the cycle after the strobe
        st_next.rdata = regRd ? rb : 8'h00;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            st_reg <= odm_pkg::STATE_RST;
        else
            st_reg <= st_next;
    end

    assign regRdata = st_reg.rdata;
    assign txOff = st_reg.txOff;

    // ---- checks ----
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    logic [31:0] lagCnt;

    // cycles the transmitter state disagrees with its demand
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            lagCnt <= 32'h0000_0000;
        else if (st_reg.txOff != (st_reg.hwDisable | st_reg.softDisable))
            lagCnt <= lagCnt + 32'h0000_0001;
        else
            lagCnt <= 32'h0000_0000;
    end

    sequence sRdDiag(logic [7:0] a);
        regRd && regAddr == {1'b1, a};
    endsequence

    sequence sRdId(logic [7:0] a);
        regRd && regAddr == {1'b0, a};
    endsequence

    sequence sWriteSoft;
        regWr && regAddr == {1'b1, odm_pkg::STATUS_CONTROL};
    endsequence

    AST_WAVELENGTH: assert property (sRdId(odm_pkg::ID_WAVE_MSB) |=> regRdata == 8'h03)
        else $error("wavelength high byte wrong");
    AST_ID_CHECKSUM: assert property (sRdId(odm_pkg::ID_BASE_CHECKSUM) |=>
        regRdata == BASE_CHECKSUM)
        else $error("base checksum byte wrong");
    AST_SERIAL_FIRST: assert property (sRdId(odm_pkg::ID_SERIAL_FIRST) |=>
        regRdata == $past(serialNumber[127:120]))
        else $error("serial first character wrong");
    AST_DATE_LAST: assert property (sRdId(odm_pkg::ID_DATE_LAST) |=>
        regRdata == $past(dateCode[7:0]))
        else $error("date code last character wrong");
    AST_LIVE_SUPPLY_LSB: assert property (sRdDiag(8'h63) ##1 $past(rst_b, 2) |->
        regRdata == $past(liveSupply[7:0], 2))
        else $error("live supply low byte wrong");
    AST_LIVE_RX_MSB: assert property (sRdDiag(odm_pkg::LIVE_RXPOWER) ##1 $past(rst_b, 2) |->
        regRdata == $past(liveRxPower[15:8], 2))
        else $error("live receive power high byte wrong");
    AST_CAL_AREA: assert property (sRdDiag(odm_pkg::CAL_FIRST) |=>
        regRdata == CAL_DEFAULT)
        else $error("calibration byte not default");
    AST_DIAG_CHECKSUM: assert property (sRdDiag(odm_pkg::DIAG_CHECKSUM) |=>
        regRdata == DIAG_CHECKSUM)
        else $error("diagnostic checksum wrong");
    AST_HW_DISABLE_BIT: assert property (sRdDiag(odm_pkg::STATUS_CONTROL) ##1
        $past(rst_b, 2) |-> regRdata[7] == $past(txDisablePin, 2))
        else $error("hardware disable bit wrong");
    AST_SOFT_READBACK: assert property (sWriteSoft ##1 sRdDiag(odm_pkg::STATUS_CONTROL)
        |=> regRdata[6] == $past(regWdata[6], 2))
        else $error("soft disable readback wrong");
    AST_TX_OFF: assert property ($past(rst_b) |->
        txOff == ($past(txDisablePin) || st_reg.softDisable))
        else $error("transmitter state not the OR of disables");
    AST_FAULT_LOS: assert property (sRdDiag(odm_pkg::STATUS_CONTROL) ##1 $past(rst_b, 2) |->
        regRdata[2:1] == {$past(txFaultPin, 2), $past(rxLosPin, 2)})
        else $error("fault or loss bits wrong");
    AST_NOT_READY: assert property (sRdDiag(odm_pkg::STATUS_CONTROL) ##1 $past(rst_b, 2) |->
        regRdata[0] == !$past(dataReady, 2))
        else $error("ready bit wrong");
    AST_RESPONSE: assert property (lagCnt < 32'(RESPONSE_CYCLES))
        else $error("transmitter slow to follow disable");
    AST_TEMP_HIGH: assert property ($past(rst_b) |-> st_reg.alarmA[7] ==
        ($signed($past(st_reg.live[0])) > $signed(LIMITS[15:0])))
        else $error("temperature high alarm wrong");
    AST_RX_RESERVED: assert property (sRdDiag(odm_pkg::ALARM_FLAGS_B) |=>
        regRdata[5:0] == 6'h00)
        else $error("reserved flag bits set");
    AST_WARN_RX_LOW: assert property ($past(rst_b) |-> st_reg.warnB[6] ==
        ($past(st_reg.live[4]) < LIMITS[319:304]))
        else $error("receive low warning wrong");
    AST_RESERVED_ZERO: assert property (sRdDiag(8'h6A) or sRdDiag(8'h6F) |=>
        regRdata == 8'h00)
        else $error("reserved byte not zero");
    AST_IDLE_ZERO: assert property (!regRd |=> regRdata == 8'h00)
        else $error("read data outside read answer");

    // each flag against the stored live value, one limit each
    AST_TEMP_LOW: assert property ($past(rst_b) |-> st_reg.alarmA[6] ==
        ($signed($past(st_reg.live[0])) < $signed(LIMITS[31:16])))
        else $error("temperature low alarm wrong");

    AST_TEMP_HIGH_WARN: assert property ($past(rst_b) |-> st_reg.warnA[7] ==
        ($signed($past(st_reg.live[0])) > $signed(LIMITS[47:32])))
        else $error("temperature high warning wrong");

    AST_TEMP_LOW_WARN: assert property ($past(rst_b) |-> st_reg.warnA[6] ==
        ($signed($past(st_reg.live[0])) < $signed(LIMITS[63:48])))
        else $error("temperature low warning wrong");

    AST_SUPPLY_HIGH: assert property ($past(rst_b) |-> st_reg.alarmA[5] ==
        ($past(st_reg.live[1]) > LIMITS[79:64]))
        else $error("supply high alarm wrong");

    AST_SUPPLY_LOW: assert property ($past(rst_b) |-> st_reg.alarmA[4] ==
        ($past(st_reg.live[1]) < LIMITS[95:80]))
        else $error("supply low alarm wrong");

    AST_SUPPLY_HIGH_WARN: assert property ($past(rst_b) |-> st_reg.warnA[5] ==
        ($past(st_reg.live[1]) > LIMITS[111:96]))
        else $error("supply high warning wrong");

    AST_SUPPLY_LOW_WARN: assert property ($past(rst_b) |-> st_reg.warnA[4] ==
        ($past(st_reg.live[1]) < LIMITS[127:112]))
        else $error("supply low warning wrong");

    AST_BIAS_HIGH: assert property ($past(rst_b) |-> st_reg.alarmA[3] ==
        ($past(st_reg.live[2]) > LIMITS[143:128]))
        else $error("bias high alarm wrong");

    AST_BIAS_LOW: assert property ($past(rst_b) |-> st_reg.alarmA[2] ==
        ($past(st_reg.live[2]) < LIMITS[159:144]))
        else $error("bias low alarm wrong");

    AST_BIAS_HIGH_WARN: assert property ($past(rst_b) |-> st_reg.warnA[3] ==
        ($past(st_reg.live[2]) > LIMITS[175:160]))
        else $error("bias high warning wrong");

    AST_BIAS_LOW_WARN: assert property ($past(rst_b) |-> st_reg.warnA[2] ==
        ($past(st_reg.live[2]) < LIMITS[191:176]))
        else $error("bias low warning wrong");

    AST_TXP_HIGH: assert property ($past(rst_b) |-> st_reg.alarmA[1] ==
        ($past(st_reg.live[3]) > LIMITS[207:192]))
        else $error("transmit power high alarm wrong");

    AST_TXP_LOW: assert property ($past(rst_b) |-> st_reg.alarmA[0] ==
        ($past(st_reg.live[3]) < LIMITS[223:208]))
        else $error("transmit power low alarm wrong");

    AST_TXP_HIGH_WARN: assert property ($past(rst_b) |-> st_reg.warnA[1] ==
        ($past(st_reg.live[3]) > LIMITS[239:224]))
        else $error("transmit power high warning wrong");

    AST_TXP_LOW_WARN: assert property ($past(rst_b) |-> st_reg.warnA[0] ==
        ($past(st_reg.live[3]) < LIMITS[255:240]))
        else $error("transmit power low warning wrong");

    AST_RXP_HIGH: assert property ($past(rst_b) |-> st_reg.alarmB[7] ==
        ($past(st_reg.live[4]) > LIMITS[271:256]))
        else $error("receive power high alarm wrong");

    AST_RXP_LOW: assert property ($past(rst_b) |-> st_reg.alarmB[6] ==
        ($past(st_reg.live[4]) < LIMITS[287:272]))
        else $error("receive power low alarm wrong");

    AST_RXP_HIGH_WARN: assert property ($past(rst_b) |-> st_reg.warnB[7] ==
        ($past(st_reg.live[4]) > LIMITS[303:288]))
        else $error("receive power high warning wrong");

    AST_FLAG_RESERVED: assert property (
        st_reg.alarmB[5:0] == 6'h00 && st_reg.warnB[5:0] == 6'h00)
        else $error("reserved flag bits set");

    // the host writes ones into the reserved status bits on purpose
    AST_STATUS_RESERVED: assert property (sRdDiag(odm_pkg::STATUS_CONTROL) |=>
        regRdata[5:3] == 3'h0)
        else $error("reserved status bits set");

    AST_SOFT_HOLD: assert property (
        !(regWr && regAddr == {1'b1, odm_pkg::STATUS_CONTROL}) |=> $stable(st_reg.softDisable))
        else $error("soft bit moved without a write");

    AST_MAKER_FIRST: assert property (sRdId(odm_pkg::ID_MAKER_FIRST) |=>
        regRdata == MAKER_ID[23:16])
        else $error("maker byte wrong");

endmodule

// ### odm_diag_map_test.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
    $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module odm_diag_map_test;
    // thresholds per quantity: high alarm, low alarm, high warn, low warn
    localparam logic [19:0][15:0] LIM = {
        16'h0200, 16'h2000, 16'h0100, 16'h3000, 16'h0200, 16'h2000, 16'h0100, 16'h3000,
        16'h2000, 16'h7000, 16'h1000, 16'h8000, 16'h7800, 16'h8800, 16'h7000, 16'h9000,
        16'h0000, 16'h1400, 16'hFB00, 16'h1900};
    // each row: rx, tx, bias, supply, temp; includes exact-limit and negative cases
    localparam logic [3:0][4:0][15:0] VEC = {
        {16'h2500, 16'h2500, 16'h1800, 16'h7500, 16'h1500},
        {16'h3000, 16'h0100, 16'h8000, 16'h7000, 16'h1900},
        {16'h0050, 16'h3001, 16'h0FFF, 16'h9001, 16'h1A00},
        {16'h1000, 16'h1000, 16'h5000, 16'h8000, 16'hF000}};
    localparam logic [127:0] SERIAL = "SN0123456789ABCD";
    localparam logic [63:0]  DATE   = "0A1B2C3D";
    localparam logic [7:0]   CS_A   = 8'h3C;
    localparam logic [7:0]   CS_B   = 8'hC5;
    localparam logic [7:0]   CS_C   = 8'h96;
    localparam logic [7:0]   CAL    = 8'h11;

    logic              clk;
    logic              rst_b;
    logic [8:0]        regAddr;
    logic [7:0]        regWdata;
    logic              regWr;
    logic              regRd;
    logic [7:0]        regRdata;
    logic              txDisablePin;
    logic              txFaultPin;
    logic              rxLosPin;
    logic              dataReady;
    logic              txOff;
    logic [4:0][15:0]  live;
    int                errors;
    int                samples_checked;

    odm_diag_map #(
        .LIMITS          (LIM),
        .BASE_CHECKSUM   (CS_A),
        .EXT_CHECKSUM    (CS_B),
        .DIAG_CHECKSUM   (CS_C),
        .CAL_DEFAULT     (CAL),
        // arbitrary value
        .MAKER_ID        (24'h3C5A96),
        .RESPONSE_CYCLES (16)
    ) uut (
        .clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .txDisablePin(txDisablePin), .txFaultPin(txFaultPin), .rxLosPin(rxLosPin),
        .dataReady(dataReady), .txOff(txOff),
        .liveTemp(live[0]), .liveSupply(live[1]), .liveBias(live[2]),
        .liveTxPower(live[3]), .liveRxPower(live[4]),
        .serialNumber(SERIAL), .dateCode(DATE)
    );

    odm_host_model host (
        .clk(clk), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata)
    );

    // packs alarm a, alarm b, warn a, warn b; temperature sign-extended
    function automatic logic [31:0] exp_flags(input logic [4:0][15:0] v);
        logic signed [16:0] a;
        logic signed [16:0] b;
        logic [3:0]         hl;
        logic [31:0]        f;
        f = '0;
        for (int q = 0; q < 5; q++)
        begin
            for (int k = 0; k < 4; k++)
            begin
                a = (q == 0) ? {v[q][15], v[q]} : {1'b0, v[q]};
                b = (q == 0) ? {LIM[4*q+k][15], LIM[4*q+k]} : {1'b0, LIM[4*q+k]};
                hl[k] = (k % 2 == 0) ? (a > b) : (a < b);
            end
            if (q < 4)
                {f[31-2*q], f[30-2*q], f[15-2*q], f[14-2*q]} = hl[0+:4] == 0 ? 4'h0 :
                    {hl[0], hl[1], hl[2], hl[3]};
            else
                {f[23], f[22], f[7], f[6]} = {hl[0], hl[1], hl[2], hl[3]};
        end
        return f;
    endfunction

    task automatic rdc(input logic [8:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        `CHK(d, e)
    endtask

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        #100000;
        errors++;
        stop_test;
    end

    initial
    begin
        logic [31:0] f;
        logic [15:0] w;
        logic [7:0]  d;
        logic [7:0]  e;
        logic [8:0]  rsv [10];
        rsv = '{9'h16A, 9'h16B, 9'h16C, 9'h16D, 9'h16F, 9'h172, 9'h173, 9'h176, 9'h17F, 9'h128};
        errors = 0;
        samples_checked = 0;
        rst_b = 1'b0;
        {txDisablePin, txFaultPin, rxLosPin, dataReady} = 4'h0;
        live = '0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rdc(9'h03C, 8'h03);
        rdc(9'h03D, 8'h52);
        rdc(9'h03F, CS_A);
        rdc(9'h05F, CS_B);
        rdc(9'h15F, CS_C);
        rdc(9'h025, 8'h3C);
        rdc(9'h026, 8'h5A);
        rdc(9'h027, 8'h96);
        for (int i = 0; i < 16; i++) rdc(9'h044 + 9'(i), SERIAL[127-8*i -: 8]);
        for (int i = 0; i < 8; i++) rdc(9'h054 + 9'(i), DATE[63-8*i -: 8]);
        rdc(9'h138, CAL);
        rdc(9'h15E, CAL);
        for (int i = 0; i < 20; i++)
        begin
            rdc(9'h100 + 9'(2*i), LIM[i][15:8]);
            rdc(9'h101 + 9'(2*i), LIM[i][7:0]);
        end
        host.wr(9'h100, 8'hA5);
        rdc(9'h100, LIM[0][15:8]);
        foreach (rsv[j])
        begin
            host.wr(rsv[j], 8'hFF);
            rdc(rsv[j], 8'h00);
        end
        // every pin combination with the soft bit both ways; unused bits written as ones
        for (int i = 0; i < 32; i++)
        begin
            @(posedge clk);
            {txDisablePin, txFaultPin, rxLosPin, dataReady} <= 4'(i);
            e = {i[3], i[4], 3'h0, i[2], i[1], ~i[0]};
            host.wrrd(9'h16E, i[4] ? 8'hFF : 8'hBF, d);
            `CHK(d, e)
            host.settle(2);
            rdc(9'h16E, e);
            `CHK(txOff, i[3] | i[4])
        end
        // mid-run reset drops the soft bit, the pins still show
        @(posedge clk);
        rst_b <= 1'b0;
        #1;
        `CHK(txOff, 1'b0)
        @(posedge clk);
        rst_b <= 1'b1;
        rdc(9'h16E, 8'h86);
        `CHK(txOff, 1'b1)
        for (int v = 0; v < 4; v++)
        begin
            @(posedge clk);
            live <= VEC[v];
            host.settle(3);
            for (int b = 0; b < 10; b++)
            begin
                w = VEC[v][b/2];
                rdc(9'h160 + 9'(b), (b % 2) ? w[7:0] : w[15:8]);
            end
            f = exp_flags(VEC[v]);
            rdc(9'h170, f[31:24]);
            rdc(9'h171, f[23:16]);
            rdc(9'h174, f[15:8]);
            rdc(9'h175, f[7:0]);
        end
        stop_test;
    end
endmodule

// ### odm_host_model.sv
`timescale 1ns/100ps
module odm_host_model (
    // clock
    input  wire logic          clk,
    // register port
    output logic      [8:0]    regAddr,
    output logic      [7:0]    regWdata,
    output logic               regWr,
    output logic               regRd,
    input  wire logic [7:0]    regRdata
);
    initial
    begin
        regAddr  = '0;
        regWdata = '0;
        regWr    = 1'b0;
        regRd    = 1'b0;
    end

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk);
        regWr    <= 1'b0;
    endtask

    // write then read back with no gap, as the port allows
    task automatic wrrd(input logic [8:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk);
        regWr    <= 1'b0;
        regRd    <= 1'b1;
        @(posedge clk);
        regRd    <= 1'b0;
        #1;
        q = regRdata;
    endtask

    // data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [8:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr  <= a;
        regRd    <= 1'b1;
        @(posedge clk);
        regRd    <= 1'b0;
        #1;
        d = regRdata;
    endtask

    // host leaves the device time to act before relying on a change
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask
endmodule

// ### odm_pkg.sv
package odm_pkg;

    // register port shape
    localparam int             PAGE_BIT          = 8;

    // identification page offsets
    localparam logic [7:0]     ID_MAKER_FIRST    = 8'h25;
    localparam logic [7:0]     ID_MAKER_LAST     = 8'h27;
    localparam logic [7:0]     ID_WAVE_MSB       = 8'h3C;
    localparam logic [7:0]     ID_WAVE_LSB       = 8'h3D;
    localparam logic [7:0]     ID_BASE_CHECKSUM  = 8'h3F;
    localparam logic [7:0]     ID_SERIAL_FIRST   = 8'h44;
    localparam logic [7:0]     ID_SERIAL_LAST    = 8'h53;
    localparam logic [7:0]     ID_DATE_FIRST     = 8'h54;
    localparam logic [7:0]     ID_DATE_LAST      = 8'h5B;
    localparam logic [7:0]     ID_EXT_CHECKSUM   = 8'h5F;
    localparam logic [15:0]    WAVELENGTH_NM     = 16'h0352;

    // diagnostic page offsets, limits in table order two bytes each
    localparam logic [7:0]     TEMP_HIGH_ALARM_LIMIT    = 8'h00;
    localparam logic [7:0]     TEMP_LOW_ALARM_LIMIT     = 8'h02;
    localparam logic [7:0]     TEMP_HIGH_WARN_LIMIT     = 8'h04;
    localparam logic [7:0]     TEMP_LOW_WARN_LIMIT      = 8'h06;
    localparam logic [7:0]     SUPPLY_HIGH_ALARM_LIMIT  = 8'h08;
    localparam logic [7:0]     SUPPLY_LOW_ALARM_LIMIT   = 8'h0A;
    localparam logic [7:0]     SUPPLY_HIGH_WARN_LIMIT   = 8'h0C;
    localparam logic [7:0]     SUPPLY_LOW_WARN_LIMIT    = 8'h0E;
    localparam logic [7:0]     BIAS_HIGH_ALARM_LIMIT    = 8'h10;
    localparam logic [7:0]     BIAS_LOW_ALARM_LIMIT     = 8'h12;
    localparam logic [7:0]     BIAS_HIGH_WARN_LIMIT     = 8'h14;
    localparam logic [7:0]     BIAS_LOW_WARN_LIMIT      = 8'h16;
    localparam logic [7:0]     TXPOWER_HIGH_ALARM_LIMIT = 8'h18;
    localparam logic [7:0]     TXPOWER_LOW_ALARM_LIMIT  = 8'h1A;
    localparam logic [7:0]     TXPOWER_HIGH_WARN_LIMIT  = 8'h1C;
    localparam logic [7:0]     TXPOWER_LOW_WARN_LIMIT   = 8'h1E;
    localparam logic [7:0]     RXPOWER_HIGH_ALARM_LIMIT = 8'h20;
    localparam logic [7:0]     RXPOWER_LOW_ALARM_LIMIT  = 8'h22;
    localparam logic [7:0]     RXPOWER_HIGH_WARN_LIMIT  = 8'h24;
    localparam logic [7:0]     RXPOWER_LOW_WARN_LIMIT   = 8'h26;
    localparam logic [7:0]     LIMIT_LAST_BYTE          = 8'h27;
    localparam logic [7:0]     CAL_FIRST                = 8'h38;
    localparam logic [7:0]     CAL_LAST                 = 8'h5E;
    localparam logic [7:0]     DIAG_CHECKSUM            = 8'h5F;
    localparam logic [7:0]     LIVE_TEMPERATURE         = 8'h60;
    localparam logic [7:0]     LIVE_SUPPLY              = 8'h62;
    localparam logic [7:0]     LIVE_BIAS                = 8'h64;
    localparam logic [7:0]     LIVE_TXPOWER             = 8'h66;
    localparam logic [7:0]     LIVE_RXPOWER             = 8'h68;
    localparam logic [7:0]     LIVE_LAST_BYTE           = 8'h69;
    localparam logic [7:0]     STATUS_CONTROL           = 8'h6E;
    localparam logic [7:0]     ALARM_FLAGS_A            = 8'h70;
    localparam logic [7:0]     ALARM_FLAGS_B            = 8'h71;
    localparam logic [7:0]     WARNING_FLAGS_A          = 8'h74;
    localparam logic [7:0]     WARNING_FLAGS_B          = 8'h75;

    // status/control bit positions
    localparam int             SC_HW_DISABLE_BIT   = 7;
    localparam int             SC_SOFT_DISABLE_BIT = 6;
    localparam int             SC_TX_FAULT_BIT     = 2;
    localparam int             SC_RX_LOS_BIT       = 1;
    localparam int             SC_NOT_READY_BIT    = 0;

    // flag byte b positions for received power
    localparam int             FLAG_RX_HIGH_BIT    = 7;
    localparam int             FLAG_RX_LOW_BIT     = 6;

    // monitored quantities, also their order in the live area
    localparam int             Q_TEMP    = 0;
    localparam int             Q_RXPOWER = 4;
    localparam int             NUM_QUANT = 5;

    // soft command response time
    localparam int             CLK_MHZ          = 100;
    localparam int             RESPONSE_TIME_MS = 100;
    localparam int             RESPONSE_CYCLES  = RESPONSE_TIME_MS * 1000 * CLK_MHZ;

    typedef struct packed {
        logic [7:0]                    rdata;
        logic                          softDisable;
        logic                          txOff;
        logic [NUM_QUANT-1:0][15:0]    live;
        logic                          hwDisable;
        logic                          txFault;
        logic                          rxLos;
        logic                          notReady;
        logic [7:0]                    alarmA;
        logic [7:0]                    alarmB;
        logic [7:0]                    warnA;
        logic [7:0]                    warnB;
    } odm_state_s;

    localparam odm_state_s     STATE_RST = '0;

endpackage
